// >>> tci_pkg.sv
package tci_pkg;
    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CFG = 8'hac;   // Access configuration
    localparam logic [7:0] CMD_TH = 8'ha1;    // Access high threshold
    localparam logic [7:0] CMD_TL = 8'ha2;    // Access low threshold
    localparam logic [7:0] CMD_START = 8'h51; // Start conversions
    localparam logic [7:0] CMD_STOP = 8'h22;  // Stop conversions
    localparam logic [7:0] CMD_TEMP = 8'haa;  // Read temperature

    // ------------------------------------------------------------
    // Configuration byte layout
    // ------------------------------------------------------------
    localparam int CFG_ONESHOT = 0;  // 1 = one conversion per start
    localparam int CFG_POL = 1;      // 1 = thermostat output active high
    localparam int CFG_RES_LO = 2;   // Resolution field, two bits
    localparam int CFG_RES_HI = 3;
    localparam logic [3:0] CFG_RESET = 4'h0;  // Writable bits after reset
    localparam logic [7:0] FRAC_MASK = 8'hf0; // Fraction bits kept in low byte
    localparam logic [15:0] TH_RESET = 16'h5000; // High threshold after reset
    localparam logic [15:0] TL_RESET = 16'h4b00; // Low threshold after reset
    localparam logic [15:0] TX_NONE = 16'hffff;  // Read data for no register

    // ------------------------------------------------------------
    // Link bit counting
    // ------------------------------------------------------------
    localparam logic [3:0] BIT_LAST = 4'h7; // Eighth data bit
    localparam logic [3:0] BIT_ACK = 4'h8;  // Acknowledge slot

    // Link transfer phase
    typedef enum logic [1:0] {MODE_ADDR, MODE_WRITE, MODE_READ, MODE_IGNORE} tci_mode_t;
endpackage

// >>> tci_link.sv
`timescale 1ns/10ps
module tci_link (
    input wire logic scl,
    input wire logic link_rst,
    input wire logic sda_in,
    input wire logic [6:0] dev_addr,
    input wire logic [15:0] tx_word,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output logic [1:0] rx_idx,
    output logic rx_tgl,
    output logic rd_tgl
);
    logic [3:0] bit_cnt_reg;        // Bit position in the byte, 8 = ack
    logic [6:0] shift_reg;          // Bits received so far
    tci_pkg::tci_mode_t mode_reg;   // Phase of the current frame
    logic ack_due_reg;              // Acknowledge owed in next slot
    logic rw_reg;                   // Direction bit of the address
    logic rd_idx_reg;               // 0 = sending high byte
    logic [1:0] byte_cnt_reg;       // Written bytes since addressing
    logic [7:0] full_byte;          // Byte completed at this edge
    logic [7:0] tx_sel;             // Byte being sent
    logic tx_bit;                   // Bit being sent

    assign full_byte = {shift_reg, sda_in};
    assign tx_sel = rd_idx_reg ? tx_word[7:0] : tx_word[15:8];
    assign tx_bit = tx_sel[~bit_cnt_reg[2:0]];

    // ------------------------------------------------------------
    // Bit counter and shifter
    // ------------------------------------------------------------
    // Held in reset between frames; each START restarts it
    always_ff @(posedge scl or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 7'h00;
        end else if (bit_cnt_reg == tci_pkg::BIT_ACK) begin
            bit_cnt_reg <= 4'h0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= full_byte[6:0];
        end
    end

    // ------------------------------------------------------------
    // Byte handling
    // ------------------------------------------------------------
    // Fresh address and command after every re-addressing
    always_ff @(posedge scl or posedge link_rst) begin
        if (link_rst) begin
            mode_reg <= tci_pkg::MODE_ADDR;
            ack_due_reg <= 1'b0;
            rw_reg <= 1'b0;
            rx_byte <= 8'h00;
            rx_idx <= 2'h0;
            rx_tgl <= 1'b0;
            rd_tgl <= 1'b0;
            rd_idx_reg <= 1'b0;
            byte_cnt_reg <= 2'h0;
        end else if (bit_cnt_reg == tci_pkg::BIT_LAST) begin
            unique case (mode_reg)
                // Address byte: answer only our own address
                tci_pkg::MODE_ADDR: begin
                    ack_due_reg <= (full_byte[7:1] == dev_addr);
                    rw_reg <= full_byte[0];
                    if (full_byte[7:1] == dev_addr && full_byte[0]) begin
                        rd_tgl <= ~rd_tgl;
                    end
                end
                // Every written byte is acknowledged and handed over
                tci_pkg::MODE_WRITE: begin
                    ack_due_reg <= 1'b1;
                    rx_byte <= full_byte;
                    rx_idx <= byte_cnt_reg;
                    rx_tgl <= ~rx_tgl;
                    if (byte_cnt_reg != 2'h3) begin
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                    end
                end
                tci_pkg::MODE_READ, tci_pkg::MODE_IGNORE: begin
                    ack_due_reg <= 1'b0;
                end
            endcase
        end else if (bit_cnt_reg == tci_pkg::BIT_ACK) begin
            ack_due_reg <= 1'b0;
            unique case (mode_reg)
                // Choose direction once the address is acknowledged
                tci_pkg::MODE_ADDR: begin
                    mode_reg <= !ack_due_reg ? tci_pkg::MODE_IGNORE :
                                rw_reg ? tci_pkg::MODE_READ : tci_pkg::MODE_WRITE;
                end
                // Master NACK ends the read, ACK moves to the low byte
                tci_pkg::MODE_READ: begin
                    rd_idx_reg <= 1'b1;
                    if (sda_in) begin
                        mode_reg <= tci_pkg::MODE_IGNORE;
                    end
                end
                tci_pkg::MODE_WRITE, tci_pkg::MODE_IGNORE: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data line driver
    // ------------------------------------------------------------
    // Changes only while the clock is low
    always_ff @(negedge scl or posedge link_rst) begin
        if (link_rst) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (bit_cnt_reg == tci_pkg::BIT_ACK) begin
                sda_oe <= ack_due_reg;
            end else if (mode_reg == tci_pkg::MODE_READ) begin
                sda_oe <= ~tx_bit;
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ack_slot;
        @(posedge scl) disable iff (link_rst)
        (bit_cnt_reg == tci_pkg::BIT_ACK && ack_due_reg) |-> sda_oe;
    endproperty
    a_ack_slot: assert property (p_ack_slot) else $error("ack not driven");

    property p_read_bit;
        @(posedge scl) disable iff (link_rst)
        (mode_reg == tci_pkg::MODE_READ && bit_cnt_reg < tci_pkg::BIT_ACK)
            |-> (sda_oe == ~tx_sel[~bit_cnt_reg[2:0]]);
    endproperty
    a_read_bit: assert property (p_read_bit) else $error("read bit wrong");
endmodule

// >>> tci_core.sv
`timescale 1ns/10ps
module tci_core (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [6:0] dev_addr,
    input wire logic conv_done,
    input wire logic [15:0] temp_in,
    output logic conv_start,
    output logic conv_active,
    output logic [1:0] conv_res,
    output logic thermostat_output
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_reg;  // First release stage
    logic rst_s2_reg;  // Reset used by the design
    logic rst_n;

    assign rst_n = rst_s2_reg;

    // Deassert in step with clk
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Bus pin watch and frame reset
    // ------------------------------------------------------------
    logic [2:0] scl_s_reg;  // Clock pin synchroniser
    logic [2:0] sda_s_reg;  // Data pin synchroniser
    logic scl_f_reg;        // Settled clock level
    logic sda_f_reg;        // Settled data level
    logic sda_next;
    logic scl_d_reg;        // Last clock synchroniser stage one sample earlier
    logic start_evt;        // START or repeated START seen
    logic stop_evt;         // STOP seen
    logic frame_rst_reg;    // Holds the link logic in reset
    logic armed_reg;        // Waiting for clock low after START

    assign sda_next = (sda_s_reg[1] == sda_s_reg[2]) ? sda_s_reg[2] : sda_f_reg;
    // Clock high on three samples around the data change; a bit time never is
    assign start_evt = scl_d_reg && scl_s_reg[2] && scl_s_reg[1] && sda_f_reg && !sda_next;
    assign stop_evt = scl_d_reg && scl_s_reg[2] && scl_s_reg[1] && !sda_f_reg && sda_next;

    // Three stages; a change counts once the last two agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_reg <= 3'h7;
            sda_s_reg <= 3'h7;
            scl_f_reg <= 1'b1;
            sda_f_reg <= 1'b1;
            scl_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s_reg[2];
            scl_s_reg <= {scl_s_reg[1:0], scl};
            sda_s_reg <= {sda_s_reg[1:0], sda_in};
            if (scl_s_reg[1] == scl_s_reg[2]) begin
                scl_f_reg <= scl_s_reg[2];
            end
            sda_f_reg <= sda_next;
        end
    end

    // Link held in reset outside frames; released with clock low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_rst_reg <= 1'b1;
            armed_reg <= 1'b0;
        end else if (start_evt || stop_evt) begin
            frame_rst_reg <= 1'b1;
            armed_reg <= start_evt;
        end else if (armed_reg && !scl_f_reg) begin
            frame_rst_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Link and event crossing
    // ------------------------------------------------------------
    logic [7:0] rx_byte;
    logic [1:0] rx_idx;     // 0 = command byte
    logic rx_tgl;
    logic rd_tgl;
    logic [15:0] tx_reg;    // Read data, stable while the link sends
    logic [2:0] rx_t_reg;   // Written byte toggle synchroniser
    logic [2:0] rd_t_reg;   // Read addressing toggle synchroniser
    logic rx_evt;
    logic rd_evt;

    tci_link u_link (
        .scl(scl),
        .link_rst(frame_rst_reg),
        .sda_in(sda_in),
        .dev_addr(dev_addr),
        .tx_word(tx_reg),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .rx_byte(rx_byte),
        .rx_idx(rx_idx),
        .rx_tgl(rx_tgl),
        .rd_tgl(rd_tgl)
    );

    // Frame reset clears the link toggles; that edge carries no byte
    assign rx_evt = (rx_t_reg[1] ^ rx_t_reg[2]) && !frame_rst_reg;
    assign rd_evt = (rd_t_reg[1] ^ rd_t_reg[2]) && !frame_rst_reg;

    // Byte data stays put for a whole byte time after its toggle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_t_reg <= 3'h0;
            rd_t_reg <= 3'h0;
        end else begin
            rx_t_reg <= {rx_t_reg[1:0], rx_tgl};
            rd_t_reg <= {rd_t_reg[1:0], rd_tgl};
        end
    end

    // ------------------------------------------------------------
    // Command decode and registers
    // ------------------------------------------------------------
    logic [7:0] cmd_reg;    // Last command byte
    logic [3:0] cfg_reg;    // Writable configuration bits
    logic [15:0] th_reg;    // high_threshold
    logic [15:0] tl_reg;    // low_threshold
    logic [15:0] temp_reg;  // Last stored temperature
    logic thf_reg;          // High flag
    logic tlf_reg;          // Low flag
    logic done_reg;         // Conversion finished flag
    logic cmd_evt;
    logic cfg_wr;
    logic start_cmd;
    logic stop_cmd;
    logic hi_hit;
    logic lo_hit;
    logic [7:0] cfg_full;

    // Signed comparison of two temperature words
    function automatic logic tci_gt(input logic [15:0] a, input logic [15:0] b);
        return $signed(a) > $signed(b);
    endfunction

    assign cmd_evt = rx_evt && (rx_idx == 2'h0);
    assign cfg_wr = rx_evt && (rx_idx == 2'h1) && (cmd_reg == tci_pkg::CMD_CFG);
    assign start_cmd = cmd_evt && (rx_byte == tci_pkg::CMD_START);
    assign stop_cmd = cmd_evt && (rx_byte == tci_pkg::CMD_STOP);
    assign hi_hit = tci_gt(temp_in, th_reg);
    assign lo_hit = !tci_gt(temp_in, tl_reg);
    assign cfg_full = {done_reg, thf_reg, tlf_reg, 1'b0, cfg_reg};

    // Command and written data; unknown codes only select nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= 8'h00;
            cfg_reg <= tci_pkg::CFG_RESET;
            th_reg <= tci_pkg::TH_RESET;
            tl_reg <= tci_pkg::TL_RESET;
        end else if (cmd_evt) begin
            cmd_reg <= rx_byte;
        end else if (rx_evt) begin
            if (cfg_wr) begin
                cfg_reg <= rx_byte[3:0];
            end
            if (cmd_reg == tci_pkg::CMD_TH && rx_idx == 2'h1) begin
                th_reg[15:8] <= rx_byte;
            end
            if (cmd_reg == tci_pkg::CMD_TH && rx_idx == 2'h2) begin
                th_reg[7:0] <= rx_byte & tci_pkg::FRAC_MASK;
            end
            if (cmd_reg == tci_pkg::CMD_TL && rx_idx == 2'h1) begin
                tl_reg[15:8] <= rx_byte;
            end
            if (cmd_reg == tci_pkg::CMD_TL && rx_idx == 2'h2) begin
                tl_reg[7:0] <= rx_byte & tci_pkg::FRAC_MASK;
            end
        end
    end

    // Status flags; a new event wins over a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thf_reg <= 1'b0;
            tlf_reg <= 1'b0;
            done_reg <= 1'b0;
            temp_reg <= 16'h0000;
        end else begin
            thf_reg <= (conv_done && hi_hit) || (thf_reg && !cfg_wr);
            tlf_reg <= (conv_done && lo_hit) || (tlf_reg && !cfg_wr);
            done_reg <= conv_done || (done_reg && !start_cmd);
            if (conv_done) begin
                temp_reg <= temp_in;
            end
        end
    end

    // Read data chosen when the read address arrives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_reg <= tci_pkg::TX_NONE;
        end else if (rd_evt) begin
            unique case (cmd_reg)
                tci_pkg::CMD_CFG: tx_reg <= {cfg_full, cfg_full};
                tci_pkg::CMD_TH: tx_reg <= th_reg;
                tci_pkg::CMD_TL: tx_reg <= tl_reg;
                tci_pkg::CMD_TEMP: tx_reg <= temp_reg;
                default: tx_reg <= tci_pkg::TX_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Conversion control
    // ------------------------------------------------------------
    logic running_reg;  // Conversions requested
    logic busy_reg;     // Conversion under way in the core
    logic pend_reg;     // One-shot start arrived while busy
    logic oneshot;
    logic launch;

    assign oneshot = cfg_reg[tci_pkg::CFG_ONESHOT];
    assign launch = (start_cmd && (!busy_reg || conv_done)) ||
                    (conv_done && running_reg && !stop_cmd && (!oneshot || pend_reg));
    assign conv_active = running_reg;
    assign conv_res = cfg_reg[tci_pkg::CFG_RES_HI:tci_pkg::CFG_RES_LO];

    // Stop lets the running conversion finish and be stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            running_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else if (stop_cmd) begin
            running_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else if (start_cmd) begin
            running_reg <= 1'b1;
            pend_reg <= busy_reg && !conv_done && oneshot;
        end else if (conv_done) begin
            pend_reg <= 1'b0;
            if (oneshot && !pend_reg) begin
                running_reg <= 1'b0;
            end
        end
    end

    // Start pulse to the converter and its busy tracking
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            conv_start <= launch;
            if (launch) begin
                busy_reg <= 1'b1;
            end else if (conv_done) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Thermostat
    // ------------------------------------------------------------
    logic active_reg;  // Alarm state with hysteresis

    // Set above the high mark, cleared at or below the low mark
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
            thermostat_output <= 1'b1;
        end else begin
            if (conv_done && hi_hit) begin
                active_reg <= 1'b1;
            end else if (conv_done && lo_hit) begin
                active_reg <= 1'b0;
            end
            thermostat_output <= ~(active_reg ^ cfg_reg[tci_pkg::CFG_POL]);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cfg_store;
        cfg_wr |=> (cfg_reg == $past(rx_byte[3:0]));
    endproperty
    a_cfg_store: assert property (p_cfg_store) else $error("config not stored");

    property p_flag_clear;
        (cfg_wr && !conv_done) |=> (!thf_reg && !tlf_reg);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

    property p_cfg_08;
        (cfg_reg == 4'h8) |-> (conv_res == 2'h2 && !oneshot)
            ##1 (thermostat_output == !$past(active_reg));
    endproperty
    a_cfg_08: assert property (p_cfg_08) else $error("08h mode wrong");

    property p_th_msb;
        (rx_evt && rx_idx == 2'h1 && cmd_reg == tci_pkg::CMD_TH) |=> (th_reg[15:8] == $past(rx_byte));
    endproperty
    a_th_msb: assert property (p_th_msb) else $error("high msb not loaded");

    property p_tl_lsb;
        (rx_evt && rx_idx == 2'h2 && cmd_reg == tci_pkg::CMD_TL)
            |=> (tl_reg[7:0] == ($past(rx_byte) & tci_pkg::FRAC_MASK));
    endproperty
    a_tl_lsb: assert property (p_tl_lsb) else $error("low lsb not loaded");

    property p_start;
        (start_cmd && !busy_reg) |=> (conv_start && running_reg) ##1 !conv_start;
    endproperty
    a_start: assert property (p_start) else $error("start not issued");

    property p_continue;
        (conv_done && running_reg && !oneshot && !stop_cmd) |=> conv_start;
    endproperty
    a_continue: assert property (p_continue) else $error("continuous stalled");

    property p_stop;
        stop_cmd |=> !running_reg;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");

    property p_no_restart;
        (conv_done && !running_reg && !start_cmd) |=> !conv_start;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("restart after stop");

    property p_oneshot;
        (conv_done && oneshot && !pend_reg && !start_cmd) |=> (!running_reg && !conv_start);
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot repeated");

    property p_unknown;
        (rx_evt && rx_idx != 2'h0 && cmd_reg != tci_pkg::CMD_CFG && cmd_reg != tci_pkg::CMD_TH
            && cmd_reg != tci_pkg::CMD_TL) |=> ($stable(cfg_reg) && $stable(th_reg) && $stable(tl_reg));
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown command wrote");

    property p_read_temp;
        (rd_evt && cmd_reg == tci_pkg::CMD_TEMP) |=> (tx_reg == $past(temp_reg));
    endproperty
    a_read_temp: assert property (p_read_temp) else $error("temperature not offered");

    property p_hyst;
        (conv_done && hi_hit) |=> active_reg
            ##1 (thermostat_output == $past(cfg_reg[tci_pkg::CFG_POL]));
    endproperty
    a_hyst: assert property (p_hyst) else $error("thermostat not asserted");

    property p_restart;
        start_evt |=> frame_rst_reg;
    endproperty
    a_restart: assert property (p_restart) else $error("link not restarted");

    c_cfg_write: cover property (cfg_wr);
    c_th_load: cover property (rx_evt && rx_idx == 2'h2 && cmd_reg == tci_pkg::CMD_TH);
    c_start: cover property (start_cmd ##[1:100] conv_start);
    c_read: cover property (rd_evt && cmd_reg == tci_pkg::CMD_TEMP);
endmodule

// >>> tci_master.sv
`timescale 1ns/10ps
// Bus master model; scl stands high between frames
module tci_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start or repeated start, with settle time for the detector
    task start();
        sda_low = 1'b0;
        #62.5 scl = 1'b1;
        #200 sda_low = 1'b1;
        #400 scl = 1'b0;
        #400;
    endtask
    // Stop closes a frame; some command sequences end in a repeated start
    task stop();
        sda_low = 1'b1;
        #62.5 scl = 1'b1;
        #200 sda_low = 1'b0;
        #400;
    endtask
    // Nine bit slots; a released slot reads the wire
    task xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            sda_low = ~d[i];
            #31.25 scl = 1'b1;
            #62.5 q[i] = sda;
            scl = 1'b0;
            #31.25;
        end
        #400;
    endtask
endmodule

// >>> tb.sv
`timescale 1ns/10ps
module tb;
    localparam logic [6:0] ADDR = 7'h48; // Bus address of the block
    logic clk = 1'b0, reset_n = 1'b0, conv_done = 1'b0, scl, sda_low, sda_out, sda_oe;
    logic conv_start, conv_active, thermostat_output;
    logic [1:0] conv_res;
    logic [8:0] q;
    logic [15:0] v, temp_in = 16'h0000;
    int error_cnt = 0, tests_run = 0, starts = 0, busy = 0, n;
    wire sda = ~(sda_low | (sda_oe & ~sda_out)); // Pull-up on the data wire
    always #25 clk = ~clk;
    tci_core DUT (.clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .dev_addr(ADDR), .conv_done(conv_done), .temp_in(temp_in),
        .conv_start(conv_start), .conv_active(conv_active), .conv_res(conv_res),
        .thermostat_output(thermostat_output));
    tci_master m (.scl(scl), .sda_low(sda_low), .sda(sda));
    // Converter stand-in: 20 clocks per conversion
    always @(posedge clk) begin
        if (conv_start) begin
            busy <= 20;
            starts <= starts + 1;
        end else if (busy != 0) begin
            busy <= busy - 1;
        end
        conv_done <= (busy == 1);
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] b);
        m.xfer({b, 1'b1}, q);
        chk(q[0], 1'b0);
    endtask
    // Address for write, then the command byte
    task wcmd(input logic [7:0] c);
        m.start();
        wr({ADDR, 1'b0});
        wr(c);
    endtask
    // Repeated start, read two bytes, NACK and stop
    task rd2();
        m.start();
        wr({ADDR, 1'b1});
        m.xfer(9'h1fe, q);
        v[15:8] = q[8:1];
        m.xfer(9'h1ff, q);
        v[7:0] = q[8:1];
        m.stop();
    endtask
    task t_cfg();
        wcmd(tci_pkg::CMD_CFG);
        wr(8'h08);
        wcmd(tci_pkg::CMD_CFG);
        rd2();
        chk(v[15:8], 8'h08);
        chk(conv_res, 2'b10);
        chk(thermostat_output, 1'b1);
    endtask
    task t_thr();
        wcmd(tci_pkg::CMD_TH);
        wr(8'h32);
        wr(8'h00);
        wcmd(tci_pkg::CMD_TL);
        wr(8'h2d);
        wr(8'h00);
        wcmd(tci_pkg::CMD_TH);
        rd2();
        chk(v, 16'h3200);
        wcmd(tci_pkg::CMD_TL);
        rd2();
        chk(v, 16'h2d00);
    endtask
    task t_conv();
        @(posedge clk) temp_in <= 16'h3300;
        wcmd(tci_pkg::CMD_START);
        m.stop();
        chk(conv_active, 1'b1);
        repeat (100) @(posedge clk);
        chk(starts >= 3, 1'b1);
        chk(thermostat_output, 1'b0);
        wcmd(tci_pkg::CMD_TEMP);
        rd2();
        chk(v, 16'h3300);
        m.start();
        wr({ADDR, 1'b1});
        m.xfer(9'h1ff, q);
        m.stop();
        chk(q[8:1], 8'h33);
        @(posedge clk) temp_in <= 16'h2d00;
        repeat (60) @(posedge clk);
        chk(thermostat_output, 1'b1);
    endtask
    task t_rest();
        wcmd(tci_pkg::CMD_STOP);
        m.stop();
        chk(conv_active, 1'b0);
        repeat (30) @(posedge clk);
        n = starts;
        wcmd(8'h5a);
        wr(8'h11);
        m.stop();
        repeat (100) @(posedge clk);
        chk(starts == n, 1'b1);
        wcmd(tci_pkg::CMD_TH);
        rd2();
        chk(v, 16'h3200);
        wcmd(tci_pkg::CMD_CFG);
        wr(8'h09);
        wcmd(tci_pkg::CMD_CFG);
        rd2();
        chk(v[14:8], 7'h09);
        wcmd(tci_pkg::CMD_START);
        m.stop();
        repeat (200) @(posedge clk);
        chk(starts == n + 1, 1'b1);
    endtask
    task stop_test();
        $display("errors %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_cfg();
        t_thr();
        t_conv();
        t_rest();
        stop_test();
    end
    // Watchdog well beyond the expected run time
    initial begin
        #1000000;
        error_cnt++;
        stop_test();
    end
endmodule
